// ==== ehf_error_status.sv ====
// sticky error status flag register of the host bridge
`timescale 1ns/1ps
module ehf_error_status
  import ehf_pkg::*;
(
  input  wire logic        mclk_i,
  input  wire logic        rst_n_i,
  // configuration access, dword addressed
  input  wire logic [7:0]  cfg_addr_i,
  input  wire logic        cfg_wr_i,
  input  wire logic        cfg_rd_i,
  input  wire logic [3:0]  cfg_be_i,
  input  wire logic [31:0] cfg_wdata_i,
  output logic      [31:0] cfg_rdata_o,
  output logic             cfg_rvalid_o,
  // event sources
  input  wire logic        sw_smi_event_i,
  input  wire logic        thermal_trip_i,
  input  wire logic        therm_smi_en_i,
  input  wire logic        therm_sci_en_i,
  input  wire logic        therm_serr_en_i,
  input  wire logic        locked_nondram_i,
  input  wire logic        refresh_req_i,
  input  wire logic        refresh_done_i,
  input  wire logic        dram_throttle_i,
  // outputs
  output logic             therm_msg_o,
  output logic [15:0]      error_status_o
);

  // ------------------------------------------------------------------
  // refresh queue
  // ------------------------------------------------------------------
  ehf_refq_if refq ();

  assign refq.req  = refresh_req_i;
  assign refq.done = refresh_done_i;

  ehf_refq u_refq (
    .mclk_i  (mclk_i),
    .rst_n_i (rst_n_i),
    .q       (refq.counter)
  );

  // ------------------------------------------------------------------
  // decode
  // ------------------------------------------------------------------
  logic [NUM_FLAGS-1:0] flag;
  wire logic [NUM_FLAGS-1:0] next_flags;

  function automatic logic [15:0] pack_flags(input logic [NUM_FLAGS-1:0] f);
    logic [15:0] w;
    w = '0;
    for (int i = 0; i < NUM_FLAGS; i++)
      w[FLAG_POS[i]] = f[i];
    return w;
  endfunction

  wire logic        hit      = (cfg_addr_i == ERROR_STATUS_OFS);
  wire logic        wr_hit   = cfg_wr_i & hit;
  wire logic        rd_hit   = cfg_rd_i & hit;
  // reserved positions have no storage, so they read zero
  wire logic [15:0] rd_word  = pack_flags(flag);
  wire logic [15:0] wr_mask  = {{8{cfg_be_i[1]}}, {8{cfg_be_i[0]}}};
  wire logic [15:0] clr_word = cfg_wdata_i[15:0] & wr_mask &
                               ERROR_STATUS_MSK;

  // ------------------------------------------------------------------
  // thermal message gating
  // ------------------------------------------------------------------
  // software is expected to enable a single message type per trip;
  // any enable counts as one message, never two
  wire logic therm_any_en = therm_smi_en_i | therm_sci_en_i |
                            therm_serr_en_i;
  // a trip seen while the flag is pending is dropped on purpose
  wire logic therm_issue  = thermal_trip_i & therm_any_en &
                            ~flag[FI_TH];

  wire logic [NUM_FLAGS-1:0] set_vec;
  assign set_vec[FI_SW] = sw_smi_event_i;
  assign set_vec[FI_TH] = therm_issue;
  assign set_vec[FI_LK] = locked_nondram_i;
  assign set_vec[FI_RF] = refq.timeout;
  assign set_vec[FI_DT] = dram_throttle_i;

  // ------------------------------------------------------------------
  // sticky flags
  // ------------------------------------------------------------------
  // rst_n_i is the power-on reset; warm resets must not reach here
  genvar g;
  generate
    for (g = 0; g < NUM_FLAGS; g++)
    begin : g_flag
      wire logic clr = wr_hit & clr_word[FLAG_POS[g]];
      // set wins over a simultaneous clear
      assign next_flags[g] = set_vec[g] | (flag[g] & ~clr);
      always_ff @(posedge mclk_i or negedge rst_n_i)
      begin
        if (!rst_n_i)
          flag[g] <= ERROR_STATUS_RST[FLAG_POS[g]];
        else
          flag[g] <= next_flags[g];
      end
    end
  endgenerate

  // ------------------------------------------------------------------
  // outputs
  // ------------------------------------------------------------------
  wire logic [31:0] next_rdata = rd_hit ? {16'h0000, rd_word} : 32'h0000_0000;

  always_ff @(posedge mclk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      cfg_rdata_o    <= 32'h0000_0000;
      cfg_rvalid_o   <= 1'b0;
      therm_msg_o    <= 1'b0;
      error_status_o <= ERROR_STATUS_RST;
    end
    else
    begin
      cfg_rdata_o    <= cfg_rd_i ? next_rdata : 32'h0000_0000;
      cfg_rvalid_o   <= cfg_rd_i;
      therm_msg_o    <= therm_issue;
      error_status_o <= pack_flags(next_flags);
    end
  end

  // ------------------------------------------------------------------
  // assertions
  // ------------------------------------------------------------------
  default clocking cb @(posedge mclk_i); endclocking
  default disable iff (!rst_n_i);

  sequence s_trip_pending;
    thermal_trip_i && therm_any_en && flag[FI_TH];
  endsequence

  sequence s_msg_quiet;
    !therm_msg_o;
  endsequence

  property p_no_msg_when_pending;
    s_trip_pending |=> s_msg_quiet;
  endproperty

  AST_SW_EVENT_SET: assert property (
    sw_smi_event_i |=> flag[FI_SW] && error_status_o[BIT_SW_EVENT])
    else $error("software event did not set its flag");

  AST_THERM_SET: assert property (
    therm_issue |=> flag[FI_TH] && therm_msg_o)
    else $error("thermal message without thermal flag");

  AST_THERM_CAUSE: assert property (
    $rose(flag[FI_TH]) |-> $past(therm_issue))
    else $error("thermal flag rose without a message");

  AST_THERM_DROP: assert property (p_no_msg_when_pending)
    else $error("thermal message sent while flag pending");

  // a message may only leave together with a freshly set flag
  AST_THERM_MSG_FRESH: assert property (
    therm_msg_o |-> $rose(flag[FI_TH]))
    else $error("thermal message while flag already set");

  AST_LOCK_SET: assert property (
    locked_nondram_i |=> flag[FI_LK])
    else $error("locked non-DRAM access not flagged");

  AST_REFR_SET: assert property (
    refq.timeout |=> flag[FI_RF] ##0 error_status_o[BIT_REFR_TO])
    else $error("refresh timeout not flagged");

  AST_REFQ_FULL: assert property (
    refq.timeout |-> refq.depth == REFQ_LIMIT)
    else $error("refresh timeout without a full queue");

  AST_THROT_SET: assert property (
    dram_throttle_i |=> flag[FI_DT] [*1] ##1 1'b1)
    else $error("throttle condition not flagged");

  AST_THROT_CLR: assert property (
    wr_hit && clr_word[BIT_THROTTLE] && !dram_throttle_i
    |=> !flag[FI_DT])
    else $error("throttle flag survived a clear");

  // only a one-write clears it, and never in a throttle cycle
  AST_THROT_FALL: assert property (
    $fell(flag[FI_DT]) |->
      $past(wr_hit && clr_word[BIT_THROTTLE] && !dram_throttle_i))
    else $error("throttle flag fell without a clear");

  AST_WRITE_ZERO_KEEPS: assert property (
    flag[FI_LK] && wr_hit && !clr_word[BIT_LOCKED_ND]
    |=> flag[FI_LK])
    else $error("writing zero changed a flag");

  AST_LOCK_FALL: assert property (
    $fell(flag[FI_LK]) |-> $past(wr_hit && clr_word[BIT_LOCKED_ND]))
    else $error("locked flag fell without a clear");

  AST_RSVD_ZERO: assert property (
    cfg_rvalid_o |->
      (cfg_rdata_o & ~{16'h0000, ERROR_STATUS_MSK}) == 32'h0)
    else $error("reserved bits read nonzero");

  AST_STATUS_RSVD: assert property (
    (error_status_o & ~ERROR_STATUS_MSK) == 16'h0000)
    else $error("reserved status bits nonzero");

  AST_UNMAPPED_ZERO: assert property (
    $past(cfg_rd_i && !hit) |-> cfg_rdata_o == 32'h0)
    else $error("unmapped read returned data");

endmodule

// ==== ehf_pkg.sv ====
// constants of the host error status flag bank
package ehf_pkg;

  // ------------------------------------------------------------------
  // register map
  // ------------------------------------------------------------------
  localparam logic [7:0]  ERROR_STATUS_OFS = 8'hc8;
  localparam logic [15:0] ERROR_STATUS_RST = 16'h0000;
  localparam logic [15:0] ERROR_STATUS_MSK = 16'h1b80;

  // ------------------------------------------------------------------
  // field positions
  // ------------------------------------------------------------------
  localparam int BIT_SW_EVENT  = 12;
  localparam int BIT_THERMAL   = 11;
  localparam int BIT_LOCKED_ND = 9;
  localparam int BIT_REFR_TO   = 8;
  localparam int BIT_THROTTLE  = 7;

  localparam int NUM_FLAGS = 5;
  localparam int FI_SW     = 0;
  localparam int FI_TH     = 1;
  localparam int FI_LK     = 2;
  localparam int FI_RF     = 3;
  localparam int FI_DT     = 4;

  localparam int FLAG_POS [NUM_FLAGS] = '{BIT_SW_EVENT, BIT_THERMAL,
                                          BIT_LOCKED_ND, BIT_REFR_TO,
                                          BIT_THROTTLE};

  // ------------------------------------------------------------------
  // refresh queue
  // ------------------------------------------------------------------
  localparam int          REFQ_W     = 11;
  localparam logic [10:0] REFQ_LIMIT = 11'h400;

  typedef logic [REFQ_W-1:0] ehf_depth_t;

endpackage

// ==== ehf_refq.sv ====
// refresh request queue depth counter with timeout detection
`timescale 1ns/1ps
module ehf_refq
  import ehf_pkg::*;
(
  input  wire logic  mclk_i,
  input  wire logic  rst_n_i,
  ehf_refq_if.counter q
);

  ehf_depth_t depth;
  logic       timeout;

  wire logic grow   = q.req & ~q.done;
  wire logic shrink = q.done & ~q.req;
  wire logic at_max = (depth == REFQ_LIMIT);
  wire logic at_min = (depth == '0);
  wire logic reach  = grow & (depth == REFQ_LIMIT - 11'h001);

  // saturate instead of wrapping so a stuck queue keeps reporting full
  wire ehf_depth_t next_depth = (grow & ~at_max) ? depth + 11'h001 :
                                (shrink & ~at_min) ? depth - 11'h001 :
                                depth;

  always_ff @(posedge mclk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      depth   <= '0;
      timeout <= 1'b0;
    end
    else
    begin
      depth   <= next_depth;
      timeout <= reach;
    end
  end

  assign q.depth   = depth;
  assign q.timeout = timeout;

  AST_REFQ_REACH: assert property (
    @(posedge mclk_i) disable iff (!rst_n_i)
    reach |=> timeout && depth == REFQ_LIMIT)
    else $error("refresh timeout not raised at queue limit");

endmodule

// ==== ehf_refq_if.sv ====
// carrier between the flag bank and its refresh queue counter
`timescale 1ns/1ps
interface ehf_refq_if;
  import ehf_pkg::*;
  logic       req;
  logic       done;
  logic       timeout;
  ehf_depth_t depth;

  modport counter (input req, input done, output timeout, output depth);
  modport user    (output req, output done, input timeout, input depth);
endinterface

// ==== ehf_tb.sv ====
// self-checking bench of the host error status flag bank
`timescale 1ns/1ps
module testbench;
  import ehf_pkg::*;
  logic        mclk_i, rst_n_i, cfg_wr_i, cfg_rd_i, cfg_rvalid_o;
  logic [7:0]  cfg_addr_i;
  logic [3:0]  cfg_be_i;
  logic [31:0] cfg_wdata_i, cfg_rdata_o, d;
  logic        sw_smi_event_i, thermal_trip_i, therm_smi_en_i;
  logic        therm_sci_en_i, therm_serr_en_i, locked_nondram_i;
  logic        refresh_req_i, refresh_done_i, dram_throttle_i;
  logic        therm_msg_o;
  logic [15:0] error_status_o;
  int          mismatches, n_compared;

  ehf_error_status ehf_error_status_i (.*);

  // ------------------------------------------------------------------
  // bus and check helpers
  // ------------------------------------------------------------------
  task automatic chk(input string what, input logic [31:0] exp, got);
    n_compared++;
    if (got !== exp)
    begin
      mismatches++;
      $display("wrong value %s: expected %h, seen %h", what, exp, got);
    end
  endtask
  task automatic rd(input logic [7:0] a);
    @(negedge mclk_i);
    cfg_addr_i = a;
    cfg_rd_i = 1'b1;
    @(negedge mclk_i);
    cfg_rd_i = 1'b0;
    chk("rvalid", 32'h1, {31'h0, cfg_rvalid_o});
    d = cfg_rdata_o;
  endtask
  task automatic wr(input logic [3:0] be, input logic [31:0] w);
    @(negedge mclk_i);
    cfg_addr_i = ERROR_STATUS_OFS;
    cfg_be_i = be;
    cfg_wdata_i = w;
    cfg_wr_i = 1'b1;
    @(negedge mclk_i);
    cfg_wr_i = 1'b0;
  endtask
  task automatic pulse(ref logic s);
    @(negedge mclk_i);
    s = 1'b1;
    @(negedge mclk_i);
    s = 1'b0;
  endtask
  task automatic st(input logic [15:0] e);
    chk("status", {16'h0, e}, {16'h0, error_status_o});
  endtask
  task wrap_up;
    $display("mismatches %0d compared %0d", mismatches, n_compared);
    if (mismatches == 0 && n_compared > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask

  // ------------------------------------------------------------------
  // scenarios
  // ------------------------------------------------------------------
  task t_sw;
    rd(ERROR_STATUS_OFS);
    chk("reset", {16'h0, ERROR_STATUS_RST}, d);
    pulse(sw_smi_event_i);
    st(16'h1000);
    wr(4'h1, 32'h1000);
    st(16'h1000);
    wr(4'h3, 32'h0);
    st(16'h1000);
    wr(4'h2, 32'h1000);
    st(16'h0);
  endtask
  task t_therm;
    // one enable at a time: two per trip is illegal setup
    for (int i = 0; i < 3; i++)
    begin
      {therm_smi_en_i, therm_sci_en_i, therm_serr_en_i} = 3'h1 << i;
      pulse(thermal_trip_i);
      chk("msg", 32'h1, {31'h0, therm_msg_o});
      st(16'h0800);
      pulse(thermal_trip_i);
      chk("msg", 32'h0, {31'h0, therm_msg_o});
      wr(4'h2, 32'h0800);
      st(16'h0);
    end
    {therm_smi_en_i, therm_sci_en_i, therm_serr_en_i} = 3'h0;
    pulse(thermal_trip_i);
    chk("msg", 32'h0, {31'h0, therm_msg_o});
    st(16'h0);
  endtask
  task t_lock_thr;
    pulse(locked_nondram_i);
    st(16'h0200);
    pulse(dram_throttle_i);
    st(16'h0280);
    wr(4'h2, 32'h0080);
    st(16'h0280);
    wr(4'h1, 32'h0080);
    st(16'h0200);
    // throttle and its clear in one cycle: the set must win
    @(negedge mclk_i);
    {cfg_be_i, cfg_wdata_i, cfg_wr_i} = {4'h1, 32'h0000_0080, 1'b1};
    dram_throttle_i = 1'b1;
    @(negedge mclk_i);
    {cfg_wr_i, dram_throttle_i} = 2'h0;
    st(16'h0280);
    wr(4'h3, 32'hffff);
    st(16'h0);
  endtask
  task t_refq;
    int n;
    repeat (1023) pulse(refresh_req_i);
    repeat (4) @(negedge mclk_i);
    st(16'h0);
    pulse(refresh_done_i);
    pulse(refresh_req_i);
    repeat (4) @(negedge mclk_i);
    st(16'h0);
    pulse(refresh_req_i);
    st(16'h0);
    // timeout lands two edges after the last request; bounded wait
    n = 0;
    while (n < 4 && error_status_o[BIT_REFR_TO] !== 1'b1)
    begin
      @(negedge mclk_i);
      n++;
    end
    st(16'h0100);
    chk("refresh latency", 32'h1, n);
    if (n == 4)
      wrap_up;
  endtask
  task t_resv;
    @(negedge mclk_i);
    {sw_smi_event_i, thermal_trip_i, therm_smi_en_i} = 3'h7;
    {locked_nondram_i, dram_throttle_i} = 2'h3;
    @(negedge mclk_i);
    {sw_smi_event_i, thermal_trip_i, therm_smi_en_i} = 3'h0;
    {locked_nondram_i, dram_throttle_i} = 2'h0;
    rd(ERROR_STATUS_OFS);
    chk("read", {16'h0, ERROR_STATUS_MSK}, d);
    rd(8'hcc);
    chk("unmapped", 32'h0, d);
    wr(4'hf, 32'hffff_e07f);
    st(ERROR_STATUS_MSK);
    wr(4'hf, 32'hffff_ffff);
    rd(ERROR_STATUS_OFS);
    chk("cleared", 32'h0, d);
  endtask

  // ------------------------------------------------------------------
  // clock, reset, sequence
  // ------------------------------------------------------------------
  initial
  begin
    mclk_i = 1'b0;
    forever #2 mclk_i = ~mclk_i;
  end
  initial
  begin
    #200us;
    mismatches++;
    wrap_up;
  end
  initial
  begin
    {cfg_wr_i, cfg_rd_i, cfg_addr_i, cfg_be_i, cfg_wdata_i} = '0;
    {sw_smi_event_i, thermal_trip_i, therm_smi_en_i} = 3'h0;
    {therm_sci_en_i, therm_serr_en_i, locked_nondram_i} = 3'h0;
    {refresh_req_i, refresh_done_i, dram_throttle_i} = 3'h0;
    rst_n_i = 1'b0;
    // count rising edges so the time-zero clock step is no edge
    repeat (4) @(posedge mclk_i);
    @(negedge mclk_i);
    rst_n_i = 1'b1;
    t_sw;
    t_therm;
    t_lock_thr;
    t_refq;
    t_resv;
    wrap_up;
  end
endmodule
